// ===== hw/cmp_dac_pkg.sv
package cmp_dac_pkg;

   // Group size and field widths.
   localparam int unsigned num_comparators = 4;
   localparam int unsigned addr_width = 8;
   localparam int unsigned data_width = 32;
   localparam int unsigned reg_width = 16;
   localparam int unsigned code_width = 10;
   localparam int unsigned sel_width = 2;
   localparam int unsigned pads_per_comparator = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0] control_base_offset = 8'h00;
   localparam logic [7:0] dac_value_base_offset = 8'h10;
   localparam logic [7:0] irq_status_offset = 8'h20;
   localparam logic [7:0] irq_mask_offset = 8'h24;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions in comparator_control.
   localparam int unsigned module_enable_bit = 15;
   localparam int unsigned stop_in_idle_bit = 13;
   localparam int unsigned dac_output_enable_bit = 8;
   localparam int unsigned input_select_lsb = 6;
   localparam int unsigned external_reference_select_bit = 5;
   localparam int unsigned output_state_bit = 3;
   localparam int unsigned output_invert_bit = 1;
   localparam int unsigned range_bit = 0;

   // Writable bits of comparator_control; everything else reads zero except the read-only output_state bit.
   localparam logic [15:0] control_write_mask = 16'ha1e3;
   localparam logic [15:0] dac_value_write_mask = 16'h03ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [15:0] control_reset = 16'h0000;
   localparam logic [9:0] dac_code_reset = 10'h000;
   localparam logic [3:0] irq_reset = 4'h0;

   // Reference source selection driven to the analog reference mux.
   typedef enum logic [1:0] {
      ref_half_supply = 2'b00,
      ref_internal = 2'b01,
      ref_external = 2'b10
   } ref_source_type;

endpackage

// ===== hw/cmp_glitch_filter.sv
`timescale 1ns/10ps
`default_nettype none

// Synchronises one raw comparator result, rejects short transients, applies the
// polarity and makes a one-cycle pulse on each asserting transition.
module cmp_glitch_filter (
   input wire logic clk,
   input wire logic rst,
   input wire logic raw_async,
   input wire logic invert,
   input wire logic enable,
   output logic filtered,
   output logic pulse
);

   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic accepted_q;
   logic accepted_d;
   logic filtered_q;
   logic filtered_d;
   logic pulse_q;
   logic pulse_d;

   ////////////////////////////////////////////////////////////////////////////////
   // A change is accepted only when the second and third stages agree, so a level
   // must be seen on two successive edges before it passes on.
   assign accepted_d = (sync2_q == sync3_q) ? sync3_q : accepted_q;

   // Polarity is applied before anything downstream sees the result.
   assign filtered_d = enable & (accepted_q ^ invert);

   // Registered edge detect gives exactly one cycle per asserting transition.
   assign pulse_d = filtered_d & ~filtered_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         accepted_q <= 1'b0;
         filtered_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         sync1_q <= raw_async;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         accepted_q <= accepted_d;
         filtered_q <= filtered_d;
         pulse_q <= pulse_d;
      end
   end

   assign filtered = filtered_q;
   assign pulse = pulse_q;

endmodule

`default_nettype wire

// ===== hw/comparator_dac_control.sv
`timescale 1ns/10ps
`default_nettype none

//
// Overview of operation
// - Comparator transients shorter than one clock cycle never reach the filtered output.
// - In sleep or idle the wake request of an active comparator bypasses the filter and follows the raw result after polarity.
// - If any comparator has stop_in_idle set, every comparator is disabled during idle.
// - Each comparator makes a pulse exactly one cycle wide for the ADC trigger and interrupt.
// - Clearing module_enable powers down both the reference DAC and the comparator.
// - The two-bit input_select routes source A, B, C or D to the non-inverting input.
// - The range and external_reference_select bits pick half supply, internal or external reference.
// - The read-only output_state bit shows the comparator result after polarity.
// - The DAC value register supplies a 10-bit code to the reference DAC.
// - An enabled comparator disables the digital input buffer of its selected source pad.
// - Setting output_invert inverts the result before every consumer, clearing it passes it.
module comparator_dac_control (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cmp_dac_pkg::addr_width-1:0] paddr,
   input wire logic [cmp_dac_pkg::data_width-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [cmp_dac_pkg::data_width-1:0] prdata,
   input wire logic sleep_mode,
   input wire logic idle_mode,
   input wire logic [cmp_dac_pkg::num_comparators-1:0] comparator_raw,
   output logic [cmp_dac_pkg::num_comparators-1:0] comparator_power,
   output logic [cmp_dac_pkg::num_comparators-1:0] dac_power,
   output logic [cmp_dac_pkg::num_comparators*2-1:0] input_select,
   output logic [cmp_dac_pkg::num_comparators*2-1:0] reference_select,
   output logic [cmp_dac_pkg::num_comparators*10-1:0] dac_code,
   output logic [cmp_dac_pkg::num_comparators-1:0] dac_output_enable,
   output logic [cmp_dac_pkg::num_comparators*4-1:0] pad_input_disable,
   output logic [cmp_dac_pkg::num_comparators-1:0] filtered_out,
   output logic [cmp_dac_pkg::num_comparators-1:0] adc_trigger,
   output logic [cmp_dac_pkg::num_comparators-1:0] wake_request,
   output logic irq
);
   import cmp_dac_pkg::*;

   localparam int unsigned n = num_comparators;

   // Reference mux code from the two selection bits; external wins over range.
   function automatic logic [1:0] ref_code(input logic ext, input logic rng);
      logic [1:0] r;
      r = ref_half_supply;
      if (ext) begin
         r = ref_external;
      end else if (!rng) begin
         r = ref_internal;
      end
      return r;
   endfunction

   // One-hot pad disable for the selected source when module_enable is set.
   function automatic logic [3:0] pad_mask(input logic on, input logic [1:0] sel);
      logic [3:0] m;
      m = 4'h0;
      if (on) begin
         m[sel] = 1'b1;
      end
      return m;
   endfunction

   logic [15:0] control_q [n];
   logic [9:0] code_q [n];
   logic [n-1:0] status_q;
   logic [n-1:0] status_d;
   logic [n-1:0] mask_q;
   logic [n-1:0] mask_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pslverr_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode. Reads are captured at the setup edge, writes land at the access
   // edge; pready is always high in the access phase so every transfer is two cycles.
   logic setup_phase;
   logic write_commit;
   logic [5:0] word_index;
   logic hit_control;
   logic hit_dac;
   logic hit_status;
   logic hit_mask;
   logic addr_mapped;
   logic [1:0] sel_index;
   logic [15:0] wdata16;
   logic low_lanes;

   assign setup_phase = psel & ~penable;
   assign write_commit = psel & penable & pwrite;
   assign word_index = paddr[7:2];
   assign sel_index = paddr[3:2];
   assign hit_control = (paddr[7:4] == control_base_offset[7:4]) && (paddr[1:0] == 2'b00);
   assign hit_dac = (paddr[7:4] == dac_value_base_offset[7:4]) && (paddr[1:0] == 2'b00);
   assign hit_status = (paddr == irq_status_offset);
   assign hit_mask = (paddr == irq_mask_offset);
   assign addr_mapped = hit_control | hit_dac | hit_status | hit_mask;
   assign wdata16 = pwdata[15:0];
   assign low_lanes = pstrb[0] & pstrb[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Enable resolution. One stop_in_idle bit anywhere shuts the whole group down
   // in idle, which keeps the clock control for the group simple.
   logic [n-1:0] module_enable;
   logic [n-1:0] stop_in_idle;
   logic [n-1:0] output_invert;
   logic group_idle_stop;
   logic [n-1:0] active;
   logic low_power;

   for (genvar i = 0; i < n; i++) begin : g_fields
      assign module_enable[i] = control_q[i][module_enable_bit];
      assign stop_in_idle[i] = control_q[i][stop_in_idle_bit];
      assign output_invert[i] = control_q[i][output_invert_bit];
   end

   assign group_idle_stop = idle_mode & (|stop_in_idle);
   assign active = module_enable & {n{~group_idle_stop}};
   assign low_power = sleep_mode | idle_mode;

   ////////////////////////////////////////////////////////////////////////////////
   // Filter and pulse generation per comparator.
   logic [n-1:0] filt;
   logic [n-1:0] pulse;

   for (genvar i = 0; i < n; i++) begin : g_filter
      cmp_glitch_filter u_filter (
         .clk(clk),
         .rst(rst),
         .raw_async(comparator_raw[i]),
         .invert(output_invert[i]),
         .enable(active[i]),
         .filtered(filt[i]),
         .pulse(pulse[i])
      );
   end

   assign filtered_out = filt;
   assign adc_trigger = pulse;

   // Unfiltered path so an analog crossing can wake a stopped clock. It is
   // combinational from the pin on purpose: no edge may be needed to raise it.
   assign wake_request = {n{low_power}} & active & (comparator_raw ^ output_invert);

   ////////////////////////////////////////////////////////////////////////////////
   // Analog control outputs from register bits; the power and DAC output enables also follow active.
   for (genvar i = 0; i < n; i++) begin : g_analog
      assign comparator_power[i] = active[i];
      assign dac_power[i] = active[i];
      assign input_select[2*i +: 2] = control_q[i][input_select_lsb +: 2];
      assign reference_select[2*i +: 2] = ref_code(control_q[i][external_reference_select_bit],
                                                   control_q[i][range_bit]);
      assign dac_code[10*i +: 10] = code_q[i];
      // Gated by enable; two set bits are a software fault and both drive the pin.
      assign dac_output_enable[i] = control_q[i][dac_output_enable_bit] & active[i];
      assign pad_input_disable[4*i +: 4] = pad_mask(module_enable[i],
                                                    control_q[i][input_select_lsb +: 2]);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control and DAC registers. Only the mask bits are stored, the rest stay zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < n; i++) begin
            control_q[i] <= control_reset;
            code_q[i] <= dac_code_reset;
         end
      end else if (write_commit && low_lanes) begin
         if (hit_control) begin
            control_q[sel_index] <= wdata16 & control_write_mask;
         end
         if (hit_dac) begin
            code_q[sel_index] <= wdata16[9:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status: a pulse sets its bit, a written one clears it, and a pulse
   // in the same cycle as the clear keeps the bit set.
   assign status_d = pulse | (status_q &
                     ~((write_commit && hit_status && pstrb[0]) ? pwdata[n-1:0] : irq_reset));
   assign mask_d = (write_commit && hit_mask && pstrb[0]) ? pwdata[n-1:0] : mask_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_q <= irq_reset;
         mask_q <= irq_reset;
      end else begin
         status_q <= status_d;
         mask_q <= mask_d;
      end
   end

   // In low power the raw path also raises the line so the wake is not delayed.
   assign irq = |((status_q | wake_request) & mask_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Read multiplexer. The output_state bit shows the filtered, polarity-applied
   // result, so it lags the pin by the synchroniser, acceptance and output stages.
   logic [15:0] ctl_view;

   assign ctl_view = (control_q[sel_index] & control_write_mask) |
                     (16'(filt[sel_index]) << output_state_bit);

   always_comb begin
      prdata_d = 32'h0000_0000;
      if (hit_control) begin
         prdata_d = {16'h0000, ctl_view};
      end else if (hit_dac) begin
         prdata_d = {22'h00_0000, code_q[sel_index]};
      end else if (hit_status) begin
         prdata_d = {{(32-n){1'b0}}, status_q};
      end else if (hit_mask) begin
         prdata_d = {{(32-n){1'b0}}, mask_q};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup_phase) begin
         prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
         pslverr_q <= ~addr_mapped;
      end
   end

   assign pready = psel & penable;
   assign pslverr = psel & penable & pslverr_q;
   assign prdata = prdata_q;

   // The word index is kept only for decode readability of the group offsets.
   logic unused_index;
   assign unused_index = ^word_index;

endmodule

`default_nettype wire

// ===== bench/analog_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none

// Stands in for the four analog comparators, one input level per comparator.
module analog_cmp_model (
   input wire logic [3:0] comparator_power,
   input wire logic [3:0] level,
   output logic [3:0] comparator_raw
);
   // A powered-down comparator gives no result, so its output rests low.
   assign comparator_raw = comparator_power & level;
endmodule

`default_nettype wire

// ===== bench/cmp_dac_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module cmp_dac_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sleep_mode,
   input wire logic idle_mode,
   input wire logic [3:0] comparator_raw,
   input wire logic [3:0] comparator_power,
   input wire logic [3:0] dac_power,
   input wire logic [3:0] filtered_out,
   input wire logic [3:0] adc_trigger,
   input wire logic [3:0] wake_request
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // A long quiet stretch makes sure the filter has settled before the blip.
   sequence quiet;
      (!comparator_raw[0] && !sleep_mode && !idle_mode)[*6];
   endsequence
   sequence blip;
      quiet ##1 comparator_raw[0] ##1 !comparator_raw[0];
   endsequence
   chk_blip_rejected: assert property (blip |-> ($stable(filtered_out[0]))[*6])
      else $error("one cycle blip reached filtered output");
   chk_trig_width: assert property (adc_trigger[0] |=> !adc_trigger[0])
      else $error("trigger longer than one cycle");
   // The trigger flop and the filtered flop load on the same edge, so they rise together.
   chk_trig_on_rise: assert property ($rose(filtered_out[0]) |-> adc_trigger[0])
      else $error("no trigger with filtered rise");
   chk_trig_cause: assert property (adc_trigger[0] |-> filtered_out[0] && !$past(filtered_out[0]))
      else $error("trigger without filtered rise");
   chk_power_pair: assert property (dac_power == comparator_power)
      else $error("dac and comparator power differ");
   chk_wake_awake: assert property (!sleep_mode && !idle_mode |-> wake_request == 4'h0)
      else $error("wake request while running");
   chk_wake_off: assert property (!comparator_power[0] |-> !wake_request[0])
      else $error("wake request from unpowered comparator");
   chk_ready_access: assert property (pready == (psel && penable))
      else $error("pready outside access phase");
   chk_err_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
endmodule

bind comparator_dac_control cmp_dac_monitor mon_u (.*);

`default_nettype wire

// ===== bench/comparator_dac_control_tb.sv
`timescale 1ns/10ps
`default_nettype none

module comparator_dac_control_tb;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sleep_mode = 1'b0, idle_mode = 1'b0, pready, pslverr, irq, ev;
   logic [7:0] paddr = 8'h00, input_select, reference_select;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic [3:0] pstrb = 4'h0, level = 4'h0, comparator_raw, comparator_power, dac_power;
   logic [3:0] dac_output_enable, filtered_out, adc_trigger, wake_request;
   logic [39:0] dac_code;
   logic [15:0] pad_input_disable;
   int fails = 0, checked = 0, trig_count = 0;

   comparator_dac_control dut_u (.*);
   analog_cmp_model model_u (.comparator_power(comparator_power), .level(level),
      .comparator_raw(comparator_raw));

   // Free-running clock; trigger pulses are tallied so width and count can be judged.
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (adc_trigger[0] === 1'b1) trig_count <= trig_count + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; the wait for pready is bounded so a dead slave ends the run.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         cmp("pready", 1, 0);
         complete_run();
      end
      @(negedge clk);
   endtask
   task automatic wait_f(input logic v);
      int n;
      n = 0;
      while (filtered_out[0] !== v && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20) begin
         cmp("filter wait", v, filtered_out[0]);
         complete_run();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         cmp("control reset", 32'h0, rv);
         apb(1'b0, 8'(16 + 4 * i), 32'h0);
         cmp("dac reset", 32'h0, rv);
      end
      apb(1'b1, 8'h00, 32'hffff_fffd);
      apb(1'b0, 8'h00, 32'h0);
      cmp("control bits", 32'h0000_a1e1, rv);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      apb(1'b0, 8'h10, 32'h0);
      cmp("dac bits", 32'h3ff, rv);
      cmp("dac code", 32'h3ff, dac_code[9:0]);
      cmp("reference ext", 2'b10, reference_select[1:0]);
      cmp("dac out en", 1, dac_output_enable[0]);
      apb(1'b0, 8'h30, 32'h0);
      cmp("unmapped err", 1, ev);
      apb(1'b1, 8'h00, 32'h8001);
      cmp("reference half", 2'b00, reference_select[1:0]);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h00, 32'h8000 | 32'(i << 6));
         cmp("reference int", 2'b01, reference_select[1:0]);
         cmp("input select", i, input_select[1:0]);
         cmp("pad disable", 1 << i, pad_input_disable[3:0]);
      end
      apb(1'b1, 8'h00, 32'h0);
      cmp("comparator off", 0, {comparator_power[0], dac_power[0]});
      $display("test regs done");
   endtask
   task automatic t_filter();
      apb(1'b1, 8'h24, 32'h1);
      apb(1'b1, 8'h00, 32'h8000);
      repeat (8) @(posedge clk);
      level[0] <= 1'b1;
      @(posedge clk);
      level[0] <= 1'b0;
      repeat (8) @(negedge clk);
      cmp("blip filtered", 0, filtered_out[0]);
      @(posedge clk);
      level[0] <= 1'b1;
      wait_f(1'b1);
      repeat (3) @(negedge clk);
      cmp("pulse count", 1, trig_count);
      cmp("irq raised", 1, irq);
      apb(1'b0, 8'h00, 32'h0);
      cmp("output state", 32'h8008, rv);
      apb(1'b1, 8'h20, 32'h1);
      cmp("irq cleared", 0, irq);
      apb(1'b1, 8'h00, 32'h8002);
      wait_f(1'b0);
      apb(1'b0, 8'h00, 32'h0);
      cmp("inverted state", 32'h8002, rv);
      @(posedge clk);
      level[0] <= 1'b0;
      wait_f(1'b1);
      repeat (3) @(negedge clk);
      cmp("inverted pulse", 2, trig_count);
      apb(1'b1, 8'h24, 32'h0);
      cmp("irq masked", 0, irq);
      apb(1'b1, 8'h20, 32'h1);
      apb(1'b1, 8'h24, 32'h1);
      cmp("irq after clear", 0, irq);
      $display("test filter done");
   endtask
   task automatic t_idle();
      apb(1'b1, 8'h00, 32'h8000);
      apb(1'b1, 8'h04, 32'ha000);
      @(posedge clk);
      idle_mode <= 1'b1;
      @(negedge clk);
      cmp("idle power", 4'h0, comparator_power);
      cmp("idle pads", 8'h11, pad_input_disable[7:0]);
      @(posedge clk);
      idle_mode <= 1'b0;
      @(negedge clk);
      cmp("run power", 4'h3, dac_power);
      $display("test idle done");
   endtask
   task automatic t_sleep();
      @(posedge clk);
      sleep_mode <= 1'b1;
      level[0] <= 1'b1;
      @(negedge clk);
      cmp("wake raw", 1, wake_request[0]);
      cmp("wake irq", 1, irq);
      @(posedge clk);
      sleep_mode <= 1'b0;
      level[0] <= 1'b0;
      $display("test sleep done");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_filter();
      t_idle();
      t_sleep();
      complete_run();
   end
endmodule

`default_nettype wire
